// File: core/ddr_burst_pkg.sv
// shared constants for the two-word burst ddr sram port
package ddr_burst_pkg;
  localparam int DATA_W_NARROW = 18;
  localparam int DATA_W_WIDE = 36;
  localparam int ADDR_W_NARROW = 21;
  localparam int ADDR_W_WIDE = 20;
  localparam int LANE_W = 9;
  localparam int BURST_LEN = 2;
  localparam int SYNC_STAGES = 2;
  // small default depth so the array fits flip-flops
  localparam int MEM_ADDR_W = 6;
  localparam int CORE_CLK_MHZ = 100;
  localparam int LINK_CLK_MHZ = 12;
  localparam int PLL_OFF_MAX_MHZ = 167;
  // host link clock divider: half period in core cycles
  localparam int LINK_HALF_CYC = 4;
endpackage : ddr_burst_pkg

// File: core/ddr_burst_if.sv
// link pins between the memory controller and the burst sram
`timescale 1ns/1ps
`default_nettype none
interface ddr_burst_if #(
  parameter int DATA_W = ddr_burst_pkg::DATA_W_NARROW,
  parameter int ADDR_W = ddr_burst_pkg::ADDR_W_NARROW
);
  localparam int LANES = DATA_W / ddr_burst_pkg::LANE_W;
  logic k_clk;
  logic k_clk_n;
  logic out_clk;
  logic out_clk_n;
  logic single_clk_mode;
  logic pll_off_n;
  logic load_strobe_n;
  logic rd_wr;
  logic [ADDR_W-1:0] addr;
  logic [LANES-1:0] byte_lane_write_sel_n;
  logic [DATA_W-1:0] host_dq_o;
  logic host_dq_oe_n;
  logic [DATA_W-1:0] dev_dq_o;
  logic dev_dq_oe_n;
  logic echo_clock;
  logic echo_clock_n;
  wire [DATA_W-1:0] dq = !dev_dq_oe_n ? dev_dq_o : (!host_dq_oe_n ? host_dq_o : '0);
  modport device (
    input k_clk, k_clk_n, out_clk, out_clk_n, single_clk_mode, pll_off_n,
    input load_strobe_n, rd_wr, addr, byte_lane_write_sel_n, host_dq_o, host_dq_oe_n,
    output dev_dq_o, dev_dq_oe_n, echo_clock, echo_clock_n
  );
  modport host (
    output k_clk, k_clk_n, out_clk, out_clk_n, single_clk_mode, pll_off_n,
    output load_strobe_n, rd_wr, addr, byte_lane_write_sel_n, host_dq_o, host_dq_oe_n,
    input dev_dq_o, dev_dq_oe_n, echo_clock, echo_clock_n
  );
endinterface : ddr_burst_if
`default_nettype wire

// File: core/ddr_burst_sram.sv
// device end: two-word burst ddr sram model in core_clk logic
`timescale 1ns/1ps
`default_nettype none
module ddr_burst_sram #(
  parameter int DATA_W = ddr_burst_pkg::DATA_W_NARROW,
  parameter int ADDR_W = ddr_burst_pkg::ADDR_W_NARROW,
  parameter int MEM_ADDR_W = ddr_burst_pkg::MEM_ADDR_W
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic nrst,
  // link
  ddr_burst_if.device link,
  // user side: status
  output logic busy_q,
  output logic [1:0] words_done_q
);
  localparam int LANES = DATA_W / ddr_burst_pkg::LANE_W;
  localparam int HALF_AW = MEM_ADDR_W - 1;
  localparam int DEPTH = 1 << HALF_AW;

  initial begin
    if (DATA_W != ddr_burst_pkg::DATA_W_NARROW && DATA_W != ddr_burst_pkg::DATA_W_WIDE)
      $error("data width must be 18 or 36");
    if ((DATA_W == ddr_burst_pkg::DATA_W_NARROW && ADDR_W != ddr_burst_pkg::ADDR_W_NARROW) ||
        (DATA_W == ddr_burst_pkg::DATA_W_WIDE && ADDR_W != ddr_burst_pkg::ADDR_W_WIDE))
      $error("address width does not match data width");
    if (MEM_ADDR_W < 2 || MEM_ADDR_W > ADDR_W)
      $error("modelled depth out of range");
  end

  ////////////////////////////////////////////////////////////////////////////
  // synchronisers for everything from the link except host_dq_oe_n, which the device does not use
  logic [7:0] clk_s1_q, clk_s2_q, clk_s3_q;
  logic ld_s1_q, ld_s2_q, rw_s1_q, rw_s2_q;
  logic [ADDR_W-1:0] a_s1_q, a_s2_q;
  logic [LANES-1:0] bw_s1_q, bw_s2_q;
  logic [DATA_W-1:0] d_s1_q, d_s2_q;
  wire [7:0] clk_raw = {4'h0, link.out_clk_n, link.out_clk, link.k_clk_n, link.k_clk};
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      clk_s1_q <= 8'h00;
      clk_s2_q <= 8'h00;
      clk_s3_q <= 8'h00;
      ld_s1_q <= 1'b1;
      ld_s2_q <= 1'b1;
      rw_s1_q <= 1'b1;
      rw_s2_q <= 1'b1;
      a_s1_q <= '0;
      a_s2_q <= '0;
      bw_s1_q <= '1;
      bw_s2_q <= '1;
      d_s1_q <= '0;
      d_s2_q <= '0;
    end else begin
      clk_s1_q <= clk_raw;
      clk_s2_q <= clk_s1_q;
      clk_s3_q <= clk_s2_q;
      ld_s1_q <= link.load_strobe_n;
      ld_s2_q <= ld_s1_q;
      rw_s1_q <= link.rd_wr;
      rw_s2_q <= rw_s1_q;
      a_s1_q <= link.addr;
      a_s2_q <= a_s1_q;
      bw_s1_q <= link.byte_lane_write_sel_n;
      bw_s2_q <= bw_s1_q;
      d_s1_q <= link.host_dq_o;
      d_s2_q <= d_s1_q;
    end
  end
  logic mode_s1_q, mode_s2_q, pll_s1_q, pll_s2_q;
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      mode_s1_q <= 1'b0;
      mode_s2_q <= 1'b0;
      pll_s1_q <= 1'b1;
      pll_s2_q <= 1'b1;
    end else begin
      mode_s1_q <= link.single_clk_mode;
      mode_s2_q <= mode_s1_q;
      pll_s1_q <= link.pll_off_n;
      pll_s2_q <= pll_s1_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // edge detection and clock selection
  wire [7:0] rise = clk_s2_q & ~clk_s3_q;
  wire k_rise = rise[0];
  wire kn_rise = rise[1];
  // single clock mode launches on the input pair
  wire o_rise = mode_s2_q ? rise[0] : rise[2];
  wire on_rise = mode_s2_q ? rise[1] : rise[3];
  wire echo_src = mode_s2_q ? clk_s2_q[0] : clk_s2_q[2];
  wire echo_src_n = mode_s2_q ? clk_s2_q[1] : clk_s2_q[3];

  ////////////////////////////////////////////////////////////////////////////
  // command decode
  wire new_cmd = k_rise && !ld_s2_q;
  wire new_wr = new_cmd && !rw_s2_q;
  wire new_rd = new_cmd && rw_s2_q;
  // only the modelled low address bits reach the arrays
  wire [MEM_ADDR_W-1:0] cmd_addr = a_s2_q[MEM_ADDR_W-1:0];

  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_WR1 = 4'b0010,
    ST_WR2 = 4'b0100,
    ST_RD = 4'b1000
  } dev_state_t;
  dev_state_t state_q, state_d;
  logic [HALF_AW-1:0] row_q;
  logic lsb_q;
  logic [1:0] beat_q;
  logic [DATA_W-1:0] rd_word_q [2];
  // two internal arrays, one per burst word parity
  logic [DATA_W-1:0] mem_even [DEPTH];
  logic [DATA_W-1:0] mem_odd [DEPTH];

  always_comb begin
    state_d = state_q;
    unique case (state_q)
      ST_IDLE: begin
        if (new_wr) state_d = ST_WR1;
        else if (new_rd) state_d = ST_RD;
      end
      ST_WR1: if (kn_rise) state_d = ST_WR2;
      ST_WR2: if (k_rise) state_d = ST_IDLE;
      ST_RD: if (beat_q == 2'd2) state_d = ST_IDLE;
    endcase
    // back to back command on the closing edge
    if ((state_q == ST_WR2 && k_rise) || (state_q == ST_RD && beat_q == 2'd2 && k_rise)) begin
      if (new_wr) state_d = ST_WR1;
      else if (new_rd) state_d = ST_RD;
    end
  end

  // first word at loaded lsb, second at inverted lsb
  wire beat_lsb = (state_q == ST_WR2) ? ~lsb_q : lsb_q;
  wire wr_beat = (state_q == ST_WR1 && kn_rise) || (state_q == ST_WR2 && k_rise);
  wire [DATA_W-1:0] cur_word = beat_lsb ? mem_odd[row_q] : mem_even[row_q];
  wire [DATA_W-1:0] merged;
  genvar g;
  generate
    for (g = 0; g < LANES; g++) begin : g_lane
      // each select covers its own nine bits, sampled with the beat
      assign merged[g*9 +: 9] = bw_s2_q[g] ? cur_word[g*9 +: 9] : d_s2_q[g*9 +: 9];
    end
  endgenerate

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      state_q <= ST_IDLE;
      row_q <= '0;
      lsb_q <= 1'b0;
    end else begin
      state_q <= state_d;
      // address only taken with a load cycle
      if (new_cmd && state_d != state_q || new_cmd && state_q != ST_IDLE) begin
        row_q <= cmd_addr[MEM_ADDR_W-1:1];
        lsb_q <= cmd_addr[0];
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (wr_beat && beat_lsb) mem_odd[row_q] <= merged;
    if (wr_beat && !beat_lsb) mem_even[row_q] <= merged;
  end

  ////////////////////////////////////////////////////////////////////////////
  // read launch: two words, then release the bus
  // with pll on, first word waits for the complementary edge
  wire rd_start = (state_q != ST_RD || beat_q == 2'd2) && state_d == ST_RD;
  wire launch = (beat_q == 2'd0) ? (pll_s2_q ? on_rise : o_rise)
                                 : (beat_q == 2'd1 ? (pll_s2_q ? o_rise : on_rise) : 1'b0);
  logic [DATA_W-1:0] dq_q;
  logic dq_oe_n_q;
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      beat_q <= 2'd0;
      dq_q <= '0;
      dq_oe_n_q <= 1'b1;
      rd_word_q[0] <= '0;
      rd_word_q[1] <= '0;
    end else if (rd_start) begin
      beat_q <= 2'd0;
      rd_word_q[0] <= cmd_addr[0] ? mem_odd[cmd_addr[MEM_ADDR_W-1:1]]
                                  : mem_even[cmd_addr[MEM_ADDR_W-1:1]];
      rd_word_q[1] <= cmd_addr[0] ? mem_even[cmd_addr[MEM_ADDR_W-1:1]]
                                  : mem_odd[cmd_addr[MEM_ADDR_W-1:1]];
      if (beat_q == 2'd2 || state_q != ST_RD) dq_oe_n_q <= 1'b1;
    end else if (state_q == ST_RD && launch) begin
      dq_q <= rd_word_q[beat_q[0]];
      dq_oe_n_q <= 1'b0;
      beat_q <= beat_q + 2'd1;
    end else if (state_q == ST_RD && beat_q == 2'd2 && (o_rise || on_rise)) begin
      dq_oe_n_q <= 1'b1;
    end else if (state_q != ST_RD) begin
      dq_oe_n_q <= 1'b1;
    end
  end

  logic echo_q, echo_n_q;
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      echo_q <= 1'b0;
      echo_n_q <= 1'b0;
      busy_q <= 1'b0;
      words_done_q <= 2'd0;
    end else begin
      echo_q <= echo_src;
      echo_n_q <= echo_src_n;
      busy_q <= state_d != ST_IDLE;
      if (new_cmd) words_done_q <= 2'd0;
      else if (wr_beat || (state_q == ST_RD && launch)) words_done_q <= words_done_q + 2'd1;
    end
  end

  assign link.dev_dq_o = dq_q;
  assign link.dev_dq_oe_n = dq_oe_n_q;
  assign link.echo_clock = echo_q;
  assign link.echo_clock_n = echo_n_q;
endmodule : ddr_burst_sram
`default_nettype wire

// File: core/ddr_burst_ctrl.sv
// host end: memory controller issuing two-word bursts
`timescale 1ns/1ps
`default_nettype none
module ddr_burst_ctrl #(
  parameter int DATA_W = ddr_burst_pkg::DATA_W_NARROW,
  parameter int ADDR_W = ddr_burst_pkg::ADDR_W_NARROW
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic nrst,
  // link
  ddr_burst_if.host link,
  // user request
  input wire logic req_valid,
  input wire logic req_rd,
  input wire logic [ADDR_W-1:0] req_addr,
  input wire logic [DATA_W-1:0] req_wdata0,
  input wire logic [DATA_W-1:0] req_wdata1,
  input wire logic [DATA_W/9-1:0] req_bw0_n,
  input wire logic [DATA_W/9-1:0] req_bw1_n,
  input wire logic single_clk_mode,
  input wire logic pll_off_n,
  output logic req_ready_q
);
  localparam int LANES = DATA_W / ddr_burst_pkg::LANE_W;
  initial begin
    if (DATA_W != ddr_burst_pkg::DATA_W_NARROW && DATA_W != ddr_burst_pkg::DATA_W_WIDE)
      $error("data width must be 18 or 36");
  end

  ////////////////////////////////////////////////////////////////////////////
  // link clock divider: k rises at phase 0, complementary clock at phase 2
  logic [2:0] div_q;
  logic [1:0] ph_q;
  wire tick = div_q == 3'(ddr_burst_pkg::LINK_HALF_CYC / 2 - 1);
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      div_q <= 3'd0;
      ph_q <= 2'd0;
    end else if (tick) begin
      div_q <= 3'd0;
      ph_q <= ph_q + 2'd1;
    end else begin
      div_q <= div_q + 3'd1;
    end
  end
  // command changes together with the k rise; the device samples it through its synchronisers
  wire cmd_slot = tick && ph_q == 2'd3;
  // second beat moves only after the complementary rise has taken the first
  wire kn_slot = tick && ph_q == 2'd2;

  typedef enum logic [2:0] {
    H_IDLE = 3'b001,
    H_BEAT0 = 3'b010,
    H_BEAT1 = 3'b100
  } host_state_t;
  host_state_t st_q;
  logic ld_n_q, rw_q, oe_n_q, k_q, kn_q;
  logic [ADDR_W-1:0] a_q;
  logic [DATA_W-1:0] d_q, d1_q;
  logic [LANES-1:0] bw_q, bw1_q;
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      st_q <= H_IDLE;
      ld_n_q <= 1'b1;
      rw_q <= 1'b1;
      oe_n_q <= 1'b1;
      a_q <= '0;
      d_q <= '0;
      d1_q <= '0;
      bw_q <= '1;
      bw1_q <= '1;
      req_ready_q <= 1'b0;
      k_q <= 1'b0;
      kn_q <= 1'b1;
    end else begin
      if (tick) begin
        k_q <= ph_q == 2'd3 || ph_q == 2'd0;
        kn_q <= ph_q == 2'd1 || ph_q == 2'd2;
      end
      // ready only in the cycle whose closing edge is the command slot
      req_ready_q <= st_q == H_IDLE && !tick && ph_q == 2'd3;
      if (cmd_slot) begin
        unique case (st_q)
          H_IDLE, H_BEAT1: begin
            ld_n_q <= !(req_valid && req_ready_q);
            oe_n_q <= 1'b1;
            if (req_valid && req_ready_q) begin
              rw_q <= req_rd;
              a_q <= req_addr;
              // first beat taken at complementary edge, second at next k edge
              d_q <= req_wdata0;
              bw_q <= req_rd ? '1 : req_bw0_n;
              d1_q <= req_wdata1;
              bw1_q <= req_rd ? '1 : req_bw1_n;
              oe_n_q <= req_rd;
              st_q <= H_BEAT0;
            end else begin
              st_q <= H_IDLE;
            end
          end
          H_BEAT0: begin
            ld_n_q <= 1'b1;
            oe_n_q <= 1'b1;
            st_q <= H_IDLE;
          end
        endcase
      end else if (kn_slot && st_q == H_BEAT0) begin
        d_q <= d1_q;
        bw_q <= bw1_q;
        st_q <= H_BEAT1;
      end
    end
  end

  assign link.k_clk = k_q;
  assign link.k_clk_n = kn_q;
  assign link.out_clk = k_q;
  assign link.out_clk_n = kn_q;
  assign link.single_clk_mode = single_clk_mode;
  assign link.pll_off_n = pll_off_n;
  assign link.load_strobe_n = ld_n_q;
  assign link.rd_wr = rw_q;
  assign link.addr = a_q;
  assign link.byte_lane_write_sel_n = bw_q;
  assign link.host_dq_o = d_q;
  assign link.host_dq_oe_n = oe_n_q;
endmodule : ddr_burst_ctrl
`default_nettype wire

// File: test/ddr_burst_assertions.sv
// concurrent checks on the link between controller and burst sram
`timescale 1ns/1ps
`default_nettype none
module ddr_burst_assertions #(
  parameter int ADDR_W = ddr_burst_pkg::ADDR_W_NARROW
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic nrst,
  // link clocks and modes
  input wire logic k_clk,
  input wire logic out_clk,
  input wire logic single_clk_mode,
  // link command and data
  input wire logic load_strobe_n,
  input wire logic rd_wr,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic host_dq_oe_n,
  input wire logic dev_dq_oe_n,
  input wire logic echo_clock
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!nrst);
  ////////////////////////////////////////////////////////////////////////////////
  // cycles since last read load, cycles of device drive
  logic [5:0] since_rd_q;
  logic [5:0] oe_low_q;
  wire rd_load = !load_strobe_n && rd_wr;
  wire [5:0] since_rd_d = rd_load ? 6'h00 : (since_rd_q == 6'h3f ? since_rd_q : since_rd_q + 6'h01);
  wire [5:0] oe_low_d = dev_dq_oe_n ? 6'h00 : (oe_low_q == 6'h3f ? oe_low_q : oe_low_q + 6'h01);
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      since_rd_q <= 6'h3f;
      oe_low_q <= 6'h00;
    end else begin
      since_rd_q <= since_rd_d;
      oe_low_q <= oe_low_d;
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  sequence s_cmd_held;
    !load_strobe_n && $stable(addr) && $stable(rd_wr);
  endsequence
  property p_cmd_hold;
    $fell(load_strobe_n) |=> s_cmd_held [*3];
  endproperty
  property p_write_drive;
    $fell(load_strobe_n) && !rd_wr |-> ##[0:2] !host_dq_oe_n;
  endproperty
  property p_no_contention;
    !dev_dq_oe_n |-> host_dq_oe_n;
  endproperty
  property p_read_launch;
    $fell(dev_dq_oe_n) |-> since_rd_q < 6'h28;
  endproperty
  property p_burst_len;
    oe_low_q <= 6'h20;
  endproperty
  property p_idle_release;
    since_rd_q == 6'h3f |-> dev_dq_oe_n;
  endproperty
  property p_echo_out;
    $rose(out_clk) && !single_clk_mode |-> ##[0:8] echo_clock;
  endproperty
  property p_echo_k;
    $rose(k_clk) && single_clk_mode |-> ##[0:8] echo_clock;
  endproperty
  a_cmd_hold: assert property (p_cmd_hold)
    else $error("command fields moved before the input clock edge");
  a_write_drive: assert property (p_write_drive)
    else $error("write data not driven after write load");
  a_no_contention: assert property (p_no_contention)
    else $error("both ends drive the data bus");
  a_read_launch: assert property (p_read_launch)
    else $error("device drove data without a read load");
  a_burst_len: assert property (p_burst_len)
    else $error("device drive lasted beyond a two word burst");
  a_idle_release: assert property (p_idle_release)
    else $error("device still drives with no read selected");
  a_echo_out: assert property (p_echo_out)
    else $error("echo clock did not follow output clock");
  a_echo_k: assert property (p_echo_k)
    else $error("echo clock did not follow input clock in single clock mode");
endmodule : ddr_burst_assertions
`default_nettype wire

// File: test/tb_top.sv
// testbench joining controller and burst sram over the link
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic core_clk = 1'b0;
  logic nrst = 1'b0;
  logic req_valid = 1'b0;
  logic req_rd = 1'b0;
  logic [20:0] req_addr = '0;
  logic [17:0] req_wdata0 = '0;
  logic [17:0] req_wdata1 = '0;
  logic [1:0] req_bw0_n = '1;
  logic [1:0] req_bw1_n = '1;
  logic single_clk_mode = 1'b0;
  logic pll_off_n = 1'b1;
  logic req_ready_q;
  logic busy_q;
  logic [1:0] words_done_q;
  logic [17:0] rd_q[$];
  logic [17:0] w0;
  logic [17:0] w1;
  int num_errors = 0;
  int comparisons = 0;
  always #5 core_clk = ~core_clk;
  ////////////////////////////////////////////////////////////////////////////////
  ddr_burst_if link_if ();
  ddr_burst_ctrl ddr_burst_ctrl_inst (.core_clk(core_clk), .nrst(nrst), .link(link_if),
    .req_valid(req_valid), .req_rd(req_rd), .req_addr(req_addr), .req_wdata0(req_wdata0),
    .req_wdata1(req_wdata1), .req_bw0_n(req_bw0_n), .req_bw1_n(req_bw1_n),
    .single_clk_mode(single_clk_mode), .pll_off_n(pll_off_n), .req_ready_q(req_ready_q));
  ddr_burst_sram ddr_burst_sram_inst (.core_clk(core_clk), .nrst(nrst), .link(link_if),
    .busy_q(busy_q), .words_done_q(words_done_q));
  ddr_burst_assertions #(.ADDR_W(ddr_burst_pkg::ADDR_W_NARROW)) ddr_burst_assertions_inst (
    .core_clk(core_clk), .nrst(nrst), .k_clk(link_if.k_clk), .out_clk(link_if.out_clk),
    .single_clk_mode(link_if.single_clk_mode), .load_strobe_n(link_if.load_strobe_n),
    .rd_wr(link_if.rd_wr), .addr(link_if.addr), .host_dq_oe_n(link_if.host_dq_oe_n),
    .dev_dq_oe_n(link_if.dev_dq_oe_n), .echo_clock(link_if.echo_clock));
  ////////////////////////////////////////////////////////////////////////////////
  // collect each distinct word the device drives
  always @(negedge core_clk) begin
    if (link_if.dev_dq_oe_n === 1'b0 && (rd_q.size() == 0 || rd_q[rd_q.size()-1] !== link_if.dq))
      rd_q.push_back(link_if.dq);
  end
  task automatic chk(input string name, input logic [35:0] seen, input logic [35:0] exp);
    comparisons++;
    if (seen !== exp) begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk
  task automatic test_done();
    if (num_errors == 0 && comparisons > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : test_done
  task automatic wait_sig(input string name, ref logic sig, input logic lvl);
    int n;
    n = 0;
    while (sig !== lvl && n < 400) begin
      @(posedge core_clk);
      #1;
      n++;
    end
    chk(name, sig, lvl);
  endtask : wait_sig
  task automatic burst(input logic rd, input logic [20:0] a, input logic [17:0] d0,
                       input logic [17:0] d1, input logic [1:0] b0, input logic [1:0] b1);
    int n;
    n = 0;
    rd_q.delete();
    @(posedge core_clk);
    #1;
    req_rd = rd;
    req_addr = a;
    req_wdata0 = d0;
    req_wdata1 = d1;
    req_bw0_n = b0;
    req_bw1_n = b1;
    req_valid = 1'b1;
    // the edge after ready is seen high takes the request
    while (req_ready_q !== 1'b1 && n < 400) begin
      @(posedge core_clk);
      #1;
      n++;
    end
    @(posedge core_clk);
    #1 req_valid = 1'b0;
    wait_sig("busy rise", busy_q, 1'b1);
    wait_sig("busy fall", busy_q, 1'b0);
    wait_sig("dq release", link_if.dev_dq_oe_n, 1'b1);
    chk("words moved", 36'(words_done_q), 36'h0_0000_0002);
  endtask : burst
  task automatic rd_chk(input logic [20:0] a, input logic [17:0] e0, input logic [17:0] e1);
    burst(1'b1, a, 18'h0_0000, 18'h0_0000, 2'h3, 2'h3);
    chk("read word count", 36'(rd_q.size()), 36'h0_0000_0002);
    chk("read first word", rd_q.size() > 0 ? rd_q[0] : 'x, e0);
    chk("read second word", rd_q.size() > 1 ? rd_q[1] : 'x, e1);
  endtask : rd_chk
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (2) @(posedge core_clk);
    #1 nrst = 1'b1;
    burst(1'b0, 21'h00_0004, 18'h1_1111, 18'h2_2222, 2'h0, 2'h0);
    rd_chk(21'h00_0004, 18'h1_1111, 18'h2_2222);
    rd_chk(21'h00_0005, 18'h2_2222, 18'h1_1111);
    // lane 0 masked on first beat, lane 1 on second
    burst(1'b0, 21'h00_0004, 18'h3_3333, 18'h0_4444, 2'h1, 2'h2);
    w0 = (18'h3_3333 & 18'h3_fe00) | (18'h1_1111 & 18'h0_01ff);
    w1 = (18'h2_2222 & 18'h3_fe00) | (18'h0_4444 & 18'h0_01ff);
    rd_chk(21'h00_0004, w0, w1);
    @(posedge core_clk);
    #1 pll_off_n = 1'b0;
    rd_chk(21'h00_0004, w0, w1);
    @(posedge core_clk);
    #1 pll_off_n = 1'b1;
    single_clk_mode = 1'b1;
    rd_chk(21'h00_0005, w1, w0);
    @(posedge core_clk);
    #1 single_clk_mode = 1'b0;
    repeat (8) @(posedge core_clk);
    chk("idle dq enable", link_if.dev_dq_oe_n, 1'b1);
    test_done();
  end
  initial begin
    repeat (20000) @(posedge core_clk);
    num_errors++;
    test_done();
  end
endmodule : tb_top
`default_nettype wire
